//--- rtl/eeprom_pkg.sv
// Shared constants and types for the two-wire byte memory link
// Summary of operation
// - Data changes only while clock is low
// - Start is data falling, clock high
// - Ignore all activity until a start
// - Stop is data rising; returns to standby
// - Start or stop aborts control byte
// - No start/stop while reading or writing
// - Control byte: 01 command writes, addr, pad
// - Command 10 reads, then addr, pad
// - Write shifts in one byte, eight clocks
// - Eighth data clock launches internal write
// - Internal write ignores both lines
// - Start/stop before last bit cancels write
// - Write done clears counters, enters standby
// - Read loads array byte, shifts it out
// - Eighth read bit out ends in standby
// - Last pad bit ignores start and stop
// - Master frees data before pad bit ends
// - Slave drives data both high and low
// - Master starts transfers, supplies the clock
// - Sixteen byte array, four address bits
// - Write cycle leaves data line undriven
package eeprom_pkg;
    localparam int        CLK_HZ        = 20_000_000;
    localparam int        SCL_PERIOD_NS = 400;
    localparam int        QTR_CYC       = SCL_PERIOD_NS * (CLK_HZ / 1_000_000) / 4000;
    localparam int        T_WR_MS       = 5;
    localparam int        WR_CYC_DEF    = T_WR_MS * (CLK_HZ / 1000);
    localparam int        DATA_W        = 8;
    localparam int        ADDR_W        = 4;
    localparam int        MEM_DEPTH     = 16;
    localparam int        FIFO_DEPTH    = 4;
    localparam int        CMD_MSB       = 7;
    localparam int        CMD_LSB       = 6;
    localparam int        ADDR_MSB      = 5;
    localparam int        ADDR_LSB      = 2;
    localparam logic [1:0] CMD_WRITE    = 2'h1;
    localparam logic [1:0] CMD_READ     = 2'h2;
    localparam logic [1:0] PAD_BITS     = 2'h0;
    localparam logic [3:0] CNT_LAST     = 4'h7;
    localparam logic [3:0] CNT_BITS     = 4'h8;
    localparam logic [3:0] BIT_CTRL_END = 4'h7;
    localparam logic [3:0] BIT_ALL_END  = 4'hf;

    typedef enum logic [4:0] {
        S_IDLE  = 5'h01,
        S_CTRL  = 5'h02,
        S_WDATA = 5'h04,
        S_RDATA = 5'h08,
        S_WBUSY = 5'h10
    } slave_state_t;

    typedef enum logic [4:0] {
        M_IDLE  = 5'h01,
        M_START = 5'h02,
        M_BITS  = 5'h04,
        M_STOP  = 5'h08,
        M_WAIT  = 5'h10
    } master_state_t;
endpackage : eeprom_pkg

//--- rtl/link_if.sv
// Two-wire link between master and memory slave
`timescale 1ns/1ps
interface link_if;
    logic scl;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_sda_o;
    logic s_sda_oe;
    logic sda;

    // Line level; idle line floats high
    assign sda = s_sda_oe ? s_sda_o : (m_sda_oe ? m_sda_o : 1'b1);

    modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
    modport slave  (input scl, input sda, output s_sda_o, output s_sda_oe);
endinterface : link_if

//--- rtl/eeprom_slave.sv
// Memory slave end of the two-wire link
`timescale 1ns/1ps
module eeprom_slave
    import eeprom_pkg::*;
#(
    parameter int WR_CYC = WR_CYC_DEF
) (
    input  wire logic clock,
    input  wire logic rst,
    link_if.slave     link,
    output logic      write_busy,
    output logic      cmd_reject
);
    localparam int TW = $clog2(WR_CYC + 1);

    if (WR_CYC < 1) begin : g_chk
        $error("WR_CYC must be at least one");
    end

    slave_state_t       state_r;
    slave_state_t       state_nxt;
    logic [3:0]         cnt_r;
    logic [3:0]         cnt_nxt;
    logic [DATA_W-1:0]  sh_r;
    logic [DATA_W-1:0]  sh_nxt;
    logic [ADDR_W-1:0]  addr_r;
    logic [ADDR_W-1:0]  addr_nxt;
    logic [TW-1:0]      tmr_r;
    logic [TW-1:0]      tmr_nxt;
    logic               sda_o_r;
    logic               sda_o_nxt;
    logic               sda_oe_r;
    logic               sda_oe_nxt;
    logic               busy_r;
    logic               rej_r;
    logic               rej_nxt;
    logic               mem_we;
    logic [DATA_W-1:0]  mem_r [MEM_DEPTH];
    logic               scl_s1_r;
    logic               scl_s2_r;
    logic               scl_s3_r;
    logic               sda_s1_r;
    logic               sda_s2_r;
    logic               sda_s3_r;

    // Line decode after synchronisers
    wire               scl_rise   = scl_s2_r & ~scl_s3_r;
    wire               scl_fall   = ~scl_s2_r & scl_s3_r;
    wire               start_det  = scl_s2_r & scl_s3_r & ~sda_s2_r & sda_s3_r;
    wire               stop_det   = scl_s2_r & scl_s3_r & sda_s2_r & ~sda_s3_r;
    wire               last_bit   = (cnt_r == CNT_LAST);
    wire [DATA_W-1:0]  shift_in   = {sh_r[DATA_W-2:0], sda_s2_r};
    wire [1:0]         ctrl_cmd   = shift_in[CMD_MSB:CMD_LSB];
    wire [ADDR_W-1:0]  ctrl_addr  = shift_in[ADDR_MSB:ADDR_LSB];
    wire               abort_ok   = (start_det | stop_det) & ~last_bit;
    // Restart on start, standby on stop
    wire slave_state_t abort_dest = start_det ? S_CTRL : S_IDLE;

    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_r;
        sh_nxt     = sh_r;
        addr_nxt   = addr_r;
        tmr_nxt    = tmr_r;
        sda_o_nxt  = sda_o_r;
        sda_oe_nxt = sda_oe_r;
        rej_nxt    = 1'b0;
        mem_we     = 1'b0;
        case (state_r)
            S_IDLE: begin
                sda_oe_nxt = 1'b0;
                if (start_det) begin
                    state_nxt = S_CTRL;
                    cnt_nxt   = 4'h0;
                end
            end
            S_CTRL: begin
                if (abort_ok) begin
                    state_nxt = abort_dest;
                    cnt_nxt   = 4'h0;
                end else if (scl_rise) begin
                    sh_nxt  = shift_in;
                    cnt_nxt = cnt_r + 4'h1;
                    if (last_bit) begin
                        cnt_nxt  = 4'h0;
                        addr_nxt = ctrl_addr;
                        if (ctrl_cmd == CMD_WRITE) begin
                            state_nxt = S_WDATA;
                        end else if (ctrl_cmd == CMD_READ) begin
                            state_nxt = S_RDATA;
                            sh_nxt    = mem_r[ctrl_addr];
                        end else begin
                            state_nxt = S_IDLE;
                            rej_nxt   = 1'b1;
                        end
                    end
                end
            end
            S_WDATA: begin
                if (start_det | stop_det) begin
                    state_nxt = abort_dest;
                    cnt_nxt   = 4'h0;
                end else if (scl_rise) begin
                    sh_nxt  = shift_in;
                    cnt_nxt = cnt_r + 4'h1;
                    if (last_bit) begin
                        mem_we    = 1'b1;
                        state_nxt = S_WBUSY;
                        cnt_nxt   = 4'h0;
                        tmr_nxt   = TW'(WR_CYC - 1);
                    end
                end
            end
            S_RDATA: begin
                if (scl_fall) begin
                    if (cnt_r == CNT_BITS) begin
                        state_nxt  = S_IDLE;
                        cnt_nxt    = 4'h0;
                        sda_oe_nxt = 1'b0;
                    end else begin
                        sda_o_nxt  = sh_r[DATA_W-1];
                        sda_oe_nxt = 1'b1;
                        sh_nxt     = {sh_r[DATA_W-2:0], 1'b0};
                        cnt_nxt    = cnt_r + 4'h1;
                    end
                end
            end
            S_WBUSY: begin
                sda_oe_nxt = 1'b0;
                if (tmr_r == '0) begin
                    state_nxt = S_IDLE;
                    cnt_nxt   = 4'h0;
                end else begin
                    tmr_nxt = tmr_r - TW'(1);
                end
            end
            default: begin
                state_nxt  = S_IDLE;
                cnt_nxt    = 4'h0;
                sda_oe_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_s3_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_s3_r <= 1'b1;
        end else begin
            scl_s1_r <= link.scl;
            scl_s2_r <= scl_s1_r;
            scl_s3_r <= scl_s2_r;
            sda_s1_r <= link.sda;
            sda_s2_r <= sda_s1_r;
            sda_s3_r <= sda_s2_r;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_r  <= S_IDLE;
            cnt_r    <= 4'h0;
            sh_r     <= '0;
            addr_r   <= '0;
            tmr_r    <= '0;
            sda_o_r  <= 1'b0;
            sda_oe_r <= 1'b0;
            busy_r   <= 1'b0;
            rej_r    <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            sh_r     <= sh_nxt;
            addr_r   <= addr_nxt;
            tmr_r    <= tmr_nxt;
            sda_o_r  <= sda_o_nxt;
            sda_oe_r <= sda_oe_nxt;
            busy_r   <= (state_nxt == S_WBUSY);
            rej_r    <= rej_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (mem_we) begin
            mem_r[addr_r] <= shift_in;
        end
    end

    assign link.s_sda_o  = sda_o_r;
    assign link.s_sda_oe = sda_oe_r;
    assign write_busy    = busy_r;
    assign cmd_reject    = rej_r;
endmodule : eeprom_slave

//--- rtl/eeprom_master.sv
// Request FIFO and master end of the two-wire link
`timescale 1ns/1ps
module req_fifo #(
    parameter int W = 13,
    parameter int D = 4
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;

    if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
        $error("FIFO depth must be a power of two, at least two");
    end

    logic [W-1:0]  mem_r [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic          room_r;
    logic          empty_r;

    wire           push    = in_valid & room_r;
    wire           pop     = out_ready & ~empty_r;
    wire [AW:0]    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clock) begin
        if (rst) begin
            wp_r    <= '0;
            rp_r    <= '0;
            cnt_r   <= '0;
            room_r  <= 1'b1;
            empty_r <= 1'b1;
        end else begin
            wp_r    <= wp_r + AW'(push);
            rp_r    <= rp_r + AW'(pop);
            cnt_r   <= cnt_nxt;
            room_r  <= (cnt_nxt != (AW+1)'(D));
            empty_r <= (cnt_nxt == '0);
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    assign in_ready  = room_r;
    assign out_valid = ~empty_r;
    assign out_data  = mem_r[rp_r];
endmodule : req_fifo

module eeprom_master
    import eeprom_pkg::*;
#(
    parameter int WR_WAIT = WR_CYC_DEF,
    parameter int QTR     = QTR_CYC,
    parameter int FDEPTH  = FIFO_DEPTH
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_data,
    output logic                   req_ready,
    output logic                   rd_valid,
    output logic [DATA_W-1:0]      rd_data,
    link_if.master                 link
);
    localparam int FW = 1 + ADDR_W + DATA_W;
    localparam int DW = $clog2(QTR + 1);
    localparam int WW = $clog2(WR_WAIT + 1);

    if (QTR < 2 || WR_WAIT < 1) begin : g_chk
        $error("QTR must be at least two and WR_WAIT at least one");
    end

    master_state_t     state_r;
    logic [DW-1:0]     div_r;
    logic [WW-1:0]     wait_r;
    logic [1:0]        qtr_r;
    logic [3:0]        bit_r;
    logic [15:0]       tx_r;
    logic [DATA_W-1:0] rx_r;
    logic              is_rd_r;
    logic              scl_r;
    logic              so_r;
    logic              oe_r;
    logic              rdv_r;
    logic [DATA_W-1:0] rdd_r;
    logic              sda_s1_r;
    logic              sda_s2_r;
    logic              f_valid;
    logic [FW-1:0]     f_data;

    wire               tick     = (div_r == '0);
    wire               take     = (state_r == M_IDLE) & f_valid;
    wire               f_wr     = f_data[FW-1];
    wire [1:0]         f_cmd    = f_wr ? CMD_WRITE : CMD_READ;
    wire [ADDR_W-1:0]  f_addr   = f_data[DATA_W +: ADDR_W];
    wire               rd_phase = is_rd_r & bit_r[3];

    req_fifo #(.W(FW), .D(FDEPTH)) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (req_valid),
        .in_data   ({req_write, req_addr, req_data}),
        .in_ready  (req_ready),
        .out_valid (f_valid),
        .out_data  (f_data),
        .out_ready (take)
    );

    always_ff @(posedge clock) begin
        if (rst) begin
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            div_r    <= '0;
        end else begin
            sda_s1_r <= link.sda;
            sda_s2_r <= sda_s1_r;
            div_r    <= tick ? DW'(QTR - 1) : div_r - DW'(1);
        end
    end

    // Master owns clock and every start
    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= M_IDLE;
            wait_r  <= '0;
            qtr_r   <= 2'h0;
            bit_r   <= 4'h0;
            tx_r    <= '0;
            rx_r    <= '0;
            is_rd_r <= 1'b0;
            scl_r   <= 1'b1;
            so_r    <= 1'b1;
            oe_r    <= 1'b1;
            rdv_r   <= 1'b0;
            rdd_r   <= '0;
        end else begin
            rdv_r <= 1'b0;
            case (state_r)
                M_IDLE: begin
                    if (take) begin
                        tx_r    <= {f_cmd, f_addr, PAD_BITS, f_data[DATA_W-1:0]};
                        is_rd_r <= ~f_wr;
                        qtr_r   <= 2'h0;
                        state_r <= M_START;
                    end
                end
                M_START: begin
                    if (tick) begin
                        if (qtr_r == 2'h0) begin
                            so_r  <= 1'b0;
                            qtr_r <= 2'h1;
                        end else begin
                            scl_r   <= 1'b0;
                            qtr_r   <= 2'h0;
                            bit_r   <= 4'h0;
                            state_r <= M_BITS;
                        end
                    end
                end
                M_BITS: begin
                    if (tick) begin
                        qtr_r <= qtr_r + 2'h1;
                        case (qtr_r)
                            2'h0: begin
                                if (!rd_phase) begin
                                    so_r <= tx_r[15];
                                    oe_r <= 1'b1;
                                end
                                tx_r <= {tx_r[14:0], 1'b0};
                            end
                            2'h1: scl_r <= 1'b1;
                            2'h2: begin
                                if (rd_phase) begin
                                    rx_r <= {rx_r[DATA_W-2:0], sda_s2_r};
                                end
                            end
                            default: begin
                                scl_r <= 1'b0;
                                if (is_rd_r && bit_r == BIT_CTRL_END) begin
                                    oe_r <= 1'b0;
                                end
                                if (bit_r == BIT_ALL_END) begin
                                    rdv_r   <= is_rd_r;
                                    rdd_r   <= rx_r;
                                    state_r <= M_STOP;
                                end else begin
                                    bit_r <= bit_r + 4'h1;
                                end
                            end
                        endcase
                    end
                end
                M_STOP: begin
                    if (tick) begin
                        qtr_r <= qtr_r + 2'h1;
                        case (qtr_r)
                            2'h0: oe_r <= oe_r;
                            2'h1: begin
                                so_r <= 1'b0;
                                oe_r <= 1'b1;
                            end
                            2'h2: scl_r <= 1'b1;
                            default: begin
                                so_r    <= 1'b1;
                                wait_r  <= WW'(WR_WAIT);
                                state_r <= is_rd_r ? M_IDLE : M_WAIT;
                            end
                        endcase
                    end
                end
                M_WAIT: begin
                    if (wait_r == '0) begin
                        state_r <= M_IDLE;
                    end else begin
                        wait_r <= wait_r - WW'(1);
                    end
                end
                default: state_r <= M_IDLE;
            endcase
        end
    end

    assign link.scl      = scl_r;
    assign link.m_sda_o  = so_r;
    assign link.m_sda_oe = oe_r;
    assign rd_valid      = rdv_r;
    assign rd_data       = rdd_r;
endmodule : eeprom_master

//--- sim/link_chk.sv
// Checker for the link joining master and memory slave
`timescale 1ns/1ps
module link_chk #(
    parameter int WR_CYC = 50
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic scl,
    input wire logic s_sda_o,
    input wire logic s_sda_oe,
    input wire logic m_sda_oe,
    input wire logic write_busy,
    input wire logic cmd_reject,
    input wire logic b_sda_oe,
    input wire logic b_busy,
    input wire logic b_reject
);
    localparam int BUSY_LO = WR_CYC - 8;
    logic [3:0] fall_r;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Clock falls seen while slave drives
    always_ff @(posedge clock) begin
        if (rst || !s_sda_oe) fall_r <= 4'h0;
        else if ($fell(scl)) fall_r <= fall_r + 4'h1;
    end
    chk_busy_length: assert property (
        $rose(write_busy) |-> write_busy [*8] ##BUSY_LO write_busy ##1 !write_busy)
        else $error("write busy length wrong");
    chk_busy_undriven: assert property (
        write_busy |-> !s_sda_oe) else $error("data driven while busy");
    chk_busy_deaf: assert property (
        write_busy |-> !cmd_reject) else $error("command seen while busy");
    chk_reject_pulse: assert property (
        b_reject |=> !b_reject) else $error("reject longer than a cycle");
    chk_reject_idle: assert property (
        b_reject |-> !b_sda_oe && !b_busy) else $error("reject not idle");
    chk_read_eight: assert property (
        $fell(s_sda_oe) |-> fall_r == 4'h8) else $error("read not eight bits");
    chk_drive_low: assert property (
        ($rose(s_sda_oe) || (s_sda_oe && $changed(s_sda_o))) |-> !$past(scl))
        else $error("slave data changed with clock high");
    chk_reset_quiet: assert property (
        $fell(rst) |-> scl && m_sda_oe && !s_sda_oe && !write_busy)
        else $error("link not idle after reset");
    cover property ($rose(write_busy));
    cover property ($fell(s_sda_oe));
    cover property (b_reject);
    cover property ($rose(b_busy));
endmodule : link_chk

//--- sim/two_wire_byte_eeprom_slave_tb_top.sv
// Testbench for both link ends plus a fault driver
`timescale 1ns/1ps
module two_wire_byte_eeprom_slave_tb_top;
    import eeprom_pkg::*;
    localparam int     WR_SIM   = 50;
    localparam int     WAIT_SIM = WR_SIM + 10;
    logic              clock = 1'h0;
    logic              rst = 1'h1;
    logic              req_valid = 1'h0;
    logic              req_write = 1'h0;
    logic [ADDR_W-1:0] req_addr = 4'h0;
    logic [DATA_W-1:0] req_data = 8'h00;
    logic              req_ready, rd_valid, write_busy, cmd_reject, busy_b, rej_b;
    logic [DATA_W-1:0] rd_data, got;
    logic              d_scl = 1'h1, d_sda = 1'h1, d_oe = 1'h1;
    logic [7:0]        rdq[$];
    int                errors = 0, num_checks = 0, cyc = 0, rej_cnt = 0;
    link_if lk();
    link_if lk2();
    assign lk2.scl = d_scl;
    assign lk2.m_sda_o = d_sda;
    assign lk2.m_sda_oe = d_oe;
    always #25 clock = ~clock;
    eeprom_master #(.WR_WAIT(WAIT_SIM), .QTR(QTR_CYC), .FDEPTH(FIFO_DEPTH)) u_eeprom_master (
        .clock(clock), .rst(rst), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready),
        .rd_valid(rd_valid), .rd_data(rd_data), .link(lk.master));
    eeprom_slave #(.WR_CYC(WR_SIM)) u_eeprom_slave (.clock(clock), .rst(rst),
        .link(lk.slave), .write_busy(write_busy), .cmd_reject(cmd_reject));
    eeprom_slave #(.WR_CYC(WR_SIM)) u_eeprom_slave_b (.clock(clock), .rst(rst),
        .link(lk2.slave), .write_busy(busy_b), .cmd_reject(rej_b));
    link_chk #(.WR_CYC(WR_SIM)) u_link_chk (.clock(clock), .rst(rst), .scl(lk.scl),
        .s_sda_o(lk.s_sda_o), .s_sda_oe(lk.s_sda_oe), .m_sda_oe(lk.m_sda_oe),
        .write_busy(write_busy), .cmd_reject(cmd_reject),
        .b_sda_oe(lk2.s_sda_oe), .b_busy(busy_b), .b_reject(rej_b));
    always @(posedge clock) begin
        if (rd_valid === 1'h1) rdq.push_back(rd_data);
        if (rej_b === 1'h1) rej_cnt <= rej_cnt + 1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            print_verdict();
        end
    end
    task print_verdict;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    task chk_byte(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask : chk_byte
    task chk_bit(input logic g, input logic e);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask : chk_bit
    task tick(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask : tick
    task push(input logic w, input logic [3:0] a, input logic [7:0] d);
        req_valid = 1'h1; req_write = w; req_addr = a; req_data = d;
        for (int i = 0; i < 2000 && req_ready !== 1'h1; i++) tick(1);
        tick(1);
    endtask : push
    // One quarter of a driver bit period
    task q(input logic c, input logic s);
        d_scl = c; d_sda = s; tick(2);
    endtask : q
    task start_c;
        q(1'h0, 1'h1); q(1'h1, 1'h1); q(1'h1, 1'h0); q(1'h0, 1'h0);
    endtask : start_c
    task stop_c;
        d_oe = 1'h1; q(1'h0, 1'h0); q(1'h1, 1'h0); q(1'h1, 1'h1);
    endtask : stop_c
    task send(input logic [15:0] v, input int n);
        for (int i = 15; i > 15 - n; i--) begin
            q(1'h0, v[i]); q(1'h1, v[i]); q(1'h1, v[i]); q(1'h0, v[i]);
        end
    endtask : send
    task wr_b(input logic [3:0] a, input logic [7:0] d);
        start_c(); send({CMD_WRITE, a, 2'h0, d}, 16);
    endtask : wr_b
    task rd_b(input logic [3:0] a, input logic gl, output logic [7:0] g);
        start_c(); send({CMD_READ, a, 10'h000}, gl ? 7 : 8);
        if (gl) begin q(1'h0, 1'h0); q(1'h1, 1'h0); q(1'h1, 1'h1); q(1'h0, 1'h1); end
        d_oe = 1'h0;
        for (int i = 7; i >= 0; i--) begin
            q(1'h0, 1'h1); q(1'h0, 1'h1); q(1'h1, 1'h1); g[i] = lk2.sda; q(1'h1, 1'h1);
        end
        q(1'h0, 1'h1); q(1'h0, 1'h1); stop_c();
    endtask : rd_b
    task wait_idle_b;
        for (int i = 0; i < 300 && busy_b !== 1'h0; i++) tick(1);
    endtask : wait_idle_b
    task sc_queue;
        push(1'h1, 4'h0, 8'ha5); push(1'h1, 4'hf, 8'h3c); push(1'h1, 4'h7, 8'h81);
        push(1'h0, 4'h0, 8'h00); push(1'h0, 4'hf, 8'h00);
        req_valid = 1'h0;
        chk_bit(req_ready, 1'h0);
        tick(1);
        push(1'h0, 4'h7, 8'h00);
        req_valid = 1'h0;
        for (int i = 0; i < 3000 && rdq.size() < 3; i++) tick(1);
        chk_byte(rdq.pop_front(), 8'ha5);
        chk_byte(rdq.pop_front(), 8'h3c);
        chk_byte(rdq.pop_front(), 8'h81);
        tick(20);
        chk_bit(lk.scl, 1'h1);
        chk_bit(lk.sda, 1'h1);
    endtask : sc_queue
    task sc_reject;
        int r0;
        for (int c = 0; c < 4; c += 3) begin
            r0 = rej_cnt;
            start_c(); send({c[1:0], 4'h1, 10'h000}, 8); tick(8);
            chk_byte(8'(rej_cnt - r0), 8'h01);
            chk_bit(lk2.s_sda_oe, 1'h0);
            stop_c();
        end
    endtask : sc_reject
    task sc_abort;
        start_c(); send({CMD_WRITE, 4'h3, 10'h000}, 4);
        wr_b(4'h3, 8'h5a);
        tick(2);
        chk_bit(busy_b, 1'h1);
        wait_idle_b();
        chk_bit(busy_b, 1'h0);
        start_c(); send({CMD_WRITE, 4'h3, 10'h3ff}, 12); stop_c();
        rd_b(4'h3, 1'h0, got);
        chk_byte(got, 8'h5a);
    endtask : sc_abort
    task sc_busy;
        wr_b(4'h9, 8'h11);
        wr_b(4'h9, 8'hee);
        stop_c();
        wait_idle_b();
        rd_b(4'h9, 1'h1, got);
        chk_byte(got, 8'h11);
    endtask : sc_busy
    initial begin
        tick(6);
        rst = 1'h0;
        tick(2);
        sc_queue();
        sc_reject();
        sc_abort();
        sc_busy();
        print_verdict();
    end
endmodule : two_wire_byte_eeprom_slave_tb_top
